// file: include/host_port_consts.vh
// constants for the dual host bus access port
// What this block does
// - answer vme a32/d16 and a24/d16 cycles for odd modifiers 09..0f and 39..3f
// - vme sub-address comes from address bits 8 to 15
// - vme base is switch setting times 10000 hex, plus offset
// - each sub-address sits at offset sub-address times 100 hex
// - raise vme irq level 3 while samples wait in memory
// - any write to the interrupt register clears the pending flag
// - the acquisition launch command also clears the pending flag
// - irq inhibit bit 1 of the control word blocks the vme irq
// - reading the interrupt register returns one while data waits
// - samples read repeatedly at one port address, single or block
// - gpib device address taken from the switch, 0 to 29
// - first gpib character written is the target sub-address
// - one data byte follows the sub-address, except sub-address ff
// - read setup is ff, count low, count high, then sub-address
// - after setup exactly the requested byte count is returned
// - gpib sample words go out as two bytes, high byte first
// - assert gpib service request when memory fill completes
// - no parallel or serial poll answer; host scans interrupt registers
// - service request drops on interrupt register write or launch
// - gpib listen address 30 is accepted as broadcast
// - strap routes busy or matrix start marker to the front output
// - strap picks external clock input or on-board oscillator
// - jumper absent selects vme, fitted selects gpib
// - sample port is sub-address 0c on gpib and 0d on vme
// - sample pointer steps on each memory read
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define AM_A32_MASK 6'h30
`define AM_A32_VAL 6'h00
`define AM_A24_VAL 6'h30
`define AM_LOW_BITS 6'h09
`define SUB_RAM_GPIB 8'h0c
`define SUB_RAM_VME 8'h0d
`define SUB_PTR_LO 8'h0e
`define SUB_PTR_HI 8'h0f
`define SUB_CTRL 8'h10
`define SUB_LAUNCH 8'h17
`define SUB_INTR 8'h03
`define SUB_READ_SETUP 8'hff
`define CTRL_INHIBIT_BIT 1
`define CTRL_RESET 8'h00
`define GPIB_BCAST_ADDR 5'h1e
`define GPIB_LISTEN_BASE 2'b01
`define GPIB_TALK_BASE 2'b10
`define GPIB_UNLISTEN 7'h3f
`define AXI_CTRL 4'h0
`define AXI_STATUS 4'h4
`define AXI_PTR 4'h8
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// file: hdl/host_port.v
// vme, gpib and axi4-lite access logic of the digitizer board
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "host_port_consts.vh"
module host_port (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] switch_addr,
    input wire gpib_jumper,
    input wire strap_sync_sel,
    input wire strap_osc_sel,
    input wire busy_in,
    input wire matrix_start,
    input wire acq_done,
    input wire [15:0] ram_rdata,
    input wire [15:0] reg_rdata,
    input wire vme_as_n,
    input wire vme_ds_n,
    input wire vme_write_n,
    input wire [5:0] vme_am,
    input wire [31:1] vme_addr,
    input wire [31:0] vme_d_i,
    output reg [31:0] vme_d_o,
    output reg vme_d_oe,
    output reg vme_dtack_oe,
    output reg vme_irq3_oe,
    input wire [7:0] gpib_dio_i,
    output reg [7:0] gpib_dio_o,
    output reg gpib_dio_oe,
    input wire gpib_atn_n,
    input wire gpib_dav_n_i,
    output reg gpib_dav_oe,
    input wire gpib_nrfd_n_i,
    output reg gpib_nrfd_oe,
    input wire gpib_ndac_n_i,
    output reg gpib_ndac_oe,
    output reg gpib_srq_oe,
    output reg cmd_wr,
    output reg [7:0] cmd_sub,
    output reg [15:0] cmd_data,
    output reg [7:0] reg_addr,
    output reg [15:0] ram_addr,
    output reg front_out,
    output reg clk_ext_sel
);
    localparam V_IDLE = 3'b001;
    localparam V_WAIT = 3'b010;
    localparam V_ACK = 3'b100;
    localparam T_IDLE = 4'b0001;
    localparam T_SET = 4'b0010;
    localparam T_DAV = 4'b0100;
    localparam T_GAP = 4'b1000;

    // read value seen by a host at a sub-address
    function [15:0] rd_val;
        input [7:0] sub;
        input [15:0] ram;
        input [15:0] other;
        input flag;
        input [7:0] ctrl;
        input [15:0] ptr;
        begin
            if (sub == `SUB_RAM_VME || sub == `SUB_RAM_GPIB)
                rd_val = ram;
            else if (sub == `SUB_INTR)
                rd_val = {15'h0000, flag};
            else if (sub == `SUB_CTRL)
                rd_val = {8'h00, ctrl};
            else if (sub == `SUB_PTR_LO)
                rd_val = {8'h00, ptr[7:0]};
            else if (sub == `SUB_PTR_HI)
                rd_val = {8'h00, ptr[15:8]};
            else
                rd_val = other;
        end
    endfunction

    reg flag_q;
    reg [7:0] ctrl_q;
    reg [2:0] v_state_q;
    reg [7:0] v_sub_q;
    reg v_rd_q;
    reg listen_q;
    reg talk_q;
    reg acc_q;
    reg [2:0] g_idx_q;
    reg [7:0] g_sub_q;
    reg [7:0] rd_sub_q;
    reg [15:0] cnt_q;
    reg lsb_phase_q;
    reg [3:0] t_state_q;

    wire am_a24 = (vme_am & `AM_A32_MASK) == `AM_A24_VAL;
    wire am_a32 = (vme_am & `AM_A32_MASK) == `AM_A32_VAL;
    wire am_ok = (vme_am & `AM_LOW_BITS) == `AM_LOW_BITS;
    wire base_ok = am_a24 ? (vme_addr[23:16] == switch_addr[7:0]) :
        (vme_addr[31:16] == switch_addr);
    wire v_hit = !gpib_jumper && !vme_as_n && !vme_ds_n && am_ok &&
        (am_a24 || am_a32) && base_ok;
    wire v_start = (v_state_q == V_IDLE) && v_hit;
    wire v_wr = v_start && !vme_write_n;

    // gpib byte decode
    wire [4:0] my_addr = switch_addr[4:0];
    wire [6:0] g_cmd = gpib_dio_i[6:0];
    wire g_part = gpib_jumper && (!gpib_atn_n || (listen_q && !talk_q));
    wire g_take = g_part && !acc_q && !gpib_dav_n_i;
    wire g_data = g_take && gpib_atn_n;
    wire g_wr = g_data && (g_idx_q == 3'd4);

    // one write event from whichever host is active
    wire host_we = v_wr || g_wr;
    wire [7:0] host_sub = v_wr ? vme_addr[15:8] : g_sub_q;
    wire [15:0] host_dat = v_wr ? vme_d_i[15:0] : {8'h00, gpib_dio_i};
    wire clr_ev = host_we && (host_sub == `SUB_INTR ||
        host_sub == `SUB_LAUNCH);

    wire v_inc = (v_state_q == V_ACK) && vme_ds_n && v_rd_q &&
        (v_sub_q == `SUB_RAM_VME);
    wire g_inc = (t_state_q == T_DAV) && gpib_ndac_n_i && lsb_phase_q &&
        (rd_sub_q == `SUB_RAM_GPIB);

    // axi4-lite slave
    wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
        !s_axi_awready;
    wire ar_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire axi_ctrl_we = aw_take && s_axi_awaddr == `AXI_CTRL &&
        s_axi_wstrb[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `AXI_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            s_axi_awready <= aw_take;
            s_axi_wready <= aw_take;
            s_axi_arready <= ar_take;
            if (aw_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr == `AXI_CTRL) ?
                    `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `AXI_OKAY;
                case (s_axi_araddr)
                    `AXI_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
                    `AXI_STATUS:
                        s_axi_rdata <= {30'h00000000, gpib_jumper, flag_q};
                    `AXI_PTR: s_axi_rdata <= {16'h0000, ram_addr};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // shared state: pending flag, control word, sample pointer
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
            ctrl_q <= `CTRL_RESET;
            ram_addr <= 16'h0000;
            cmd_wr <= 1'b0;
            cmd_sub <= 8'h00;
            cmd_data <= 16'h0000;
        end else begin
            if (acq_done)
                flag_q <= 1'b1;
            else if (clr_ev)
                flag_q <= 1'b0;
            if (host_we && host_sub == `SUB_CTRL)
                ctrl_q <= host_dat[7:0];
            else if (axi_ctrl_we)
                ctrl_q <= s_axi_wdata[7:0];
            if (acq_done)
                ram_addr <= 16'h0000;
            else if (host_we && host_sub == `SUB_PTR_LO)
                ram_addr[7:0] <= host_dat[7:0];
            else if (host_we && host_sub == `SUB_PTR_HI)
                ram_addr[15:8] <= host_dat[7:0];
            else if (v_inc || g_inc)
                ram_addr <= ram_addr + 16'h0001;
            cmd_wr <= host_we;
            if (host_we) begin
                cmd_sub <= host_sub;
                cmd_data <= host_dat;
            end
        end
    end

    // vme slave cycle, block transfers repeat while as stays low
    always @(posedge aclk) begin
        if (!aresetn) begin
            v_state_q <= V_IDLE;
            v_sub_q <= 8'h00;
            v_rd_q <= 1'b0;
            vme_d_o <= 32'h00000000;
            vme_d_oe <= 1'b0;
            vme_dtack_oe <= 1'b0;
        end else begin
            case (v_state_q)
                V_IDLE: begin
                    if (v_start) begin
                        v_sub_q <= vme_addr[15:8];
                        v_rd_q <= vme_write_n;
                        v_state_q <= V_WAIT;
                    end
                end
                V_WAIT: begin
                    vme_d_o <= {16'h0000, rd_val(v_sub_q, ram_rdata,
                        reg_rdata, flag_q, ctrl_q, ram_addr)};
                    vme_d_oe <= v_rd_q;
                    vme_dtack_oe <= 1'b1;
                    v_state_q <= V_ACK;
                end
                V_ACK: begin
                    if (vme_ds_n) begin
                        vme_d_oe <= 1'b0;
                        vme_dtack_oe <= 1'b0;
                        v_state_q <= V_IDLE;
                    end
                end
                default: v_state_q <= V_IDLE;
            endcase
        end
    end

    // gpib acceptor and address/command decoding
    always @(posedge aclk) begin
        if (!aresetn) begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            acc_q <= 1'b0;
            gpib_nrfd_oe <= 1'b0;
            gpib_ndac_oe <= 1'b0;
            g_idx_q <= 3'd0;
            g_sub_q <= 8'h00;
            rd_sub_q <= 8'h00;
            cnt_q <= 16'h0000;
            lsb_phase_q <= 1'b0;
        end else if (!gpib_jumper) begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            acc_q <= 1'b0;
            gpib_nrfd_oe <= 1'b0;
            gpib_ndac_oe <= 1'b0;
        end else begin
            if (g_take) begin
                acc_q <= 1'b1;
                gpib_nrfd_oe <= 1'b1;
                gpib_ndac_oe <= 1'b0;
            end else if (acc_q && gpib_dav_n_i) begin
                acc_q <= 1'b0;
                gpib_ndac_oe <= 1'b1;
                gpib_nrfd_oe <= 1'b0;
            end else if (!acc_q) begin
                gpib_ndac_oe <= g_part;
                gpib_nrfd_oe <= 1'b0;
            end
            // only listen and talk addresses; polls get no answer
            if (g_take && !gpib_atn_n) begin
                g_idx_q <= 3'd0;
                if (g_cmd == {`GPIB_LISTEN_BASE, my_addr} ||
                    g_cmd == {`GPIB_LISTEN_BASE, `GPIB_BCAST_ADDR})
                    listen_q <= 1'b1;
                else if (g_cmd == `GPIB_UNLISTEN)
                    listen_q <= 1'b0;
                if (g_cmd == {`GPIB_TALK_BASE, my_addr}) begin
                    talk_q <= 1'b1;
                    listen_q <= 1'b0;
                end else if (g_cmd[6:5] == `GPIB_TALK_BASE)
                    talk_q <= 1'b0;
            end
            if (g_data) begin
                case (g_idx_q)
                    3'd0: begin
                        g_sub_q <= gpib_dio_i;
                        g_idx_q <= (gpib_dio_i == `SUB_READ_SETUP) ?
                            3'd1 : 3'd4;
                    end
                    3'd1: begin
                        cnt_q[7:0] <= gpib_dio_i;
                        g_idx_q <= 3'd2;
                    end
                    3'd2: begin
                        cnt_q[15:8] <= gpib_dio_i;
                        g_idx_q <= 3'd3;
                    end
                    3'd3: begin
                        rd_sub_q <= gpib_dio_i;
                        lsb_phase_q <= 1'b0;
                        g_idx_q <= 3'd0;
                    end
                    default: g_idx_q <= 3'd0;
                endcase
            end
            if (t_state_q == T_DAV && gpib_ndac_n_i) begin
                cnt_q <= cnt_q - 16'h0001;
                if (rd_sub_q == `SUB_RAM_GPIB)
                    lsb_phase_q <= !lsb_phase_q;
            end
        end
    end

    // gpib source handshake for talker bytes
    wire [15:0] t_word = rd_val(rd_sub_q, ram_rdata, reg_rdata, flag_q,
        ctrl_q, ram_addr);
    wire [7:0] t_byte = (rd_sub_q == `SUB_RAM_GPIB && !lsb_phase_q) ?
        t_word[15:8] : t_word[7:0];
    always @(posedge aclk) begin
        if (!aresetn) begin
            t_state_q <= T_IDLE;
            gpib_dio_o <= 8'h00;
            gpib_dio_oe <= 1'b0;
            gpib_dav_oe <= 1'b0;
        end else if (!talk_q || !gpib_atn_n || !gpib_jumper) begin
            t_state_q <= T_IDLE;
            gpib_dio_oe <= 1'b0;
            gpib_dav_oe <= 1'b0;
        end else begin
            case (t_state_q)
                T_IDLE: begin
                    if (cnt_q != 16'h0000 && gpib_nrfd_n_i) begin
                        gpib_dio_o <= t_byte;
                        gpib_dio_oe <= 1'b1;
                        t_state_q <= T_SET;
                    end else begin
                        gpib_dio_oe <= 1'b0;
                    end
                end
                T_SET: begin
                    if (gpib_nrfd_n_i) begin
                        gpib_dav_oe <= 1'b1;
                        t_state_q <= T_DAV;
                    end
                end
                T_DAV: begin
                    if (gpib_ndac_n_i) begin
                        gpib_dav_oe <= 1'b0;
                        t_state_q <= T_GAP;
                    end
                end
                T_GAP: t_state_q <= T_IDLE;
                default: t_state_q <= T_IDLE;
            endcase
        end
    end

    // interrupt lines, straps and read address
    always @(posedge aclk) begin
        if (!aresetn) begin
            vme_irq3_oe <= 1'b0;
            gpib_srq_oe <= 1'b0;
            reg_addr <= 8'h00;
            front_out <= 1'b0;
            clk_ext_sel <= 1'b0;
        end else begin
            vme_irq3_oe <= !gpib_jumper && flag_q &&
                !ctrl_q[`CTRL_INHIBIT_BIT];
            gpib_srq_oe <= gpib_jumper && flag_q;
            reg_addr <= gpib_jumper ? rd_sub_q :
                v_start ? vme_addr[15:8] : v_sub_q;
            front_out <= strap_sync_sel ? matrix_start : busy_in;
            clk_ext_sel <= !strap_osc_sel;
        end
    end
endmodule // host_port

// file: dv/host_port_sva.sv
// checker on the host port ports
`timescale 1ns/1ps
module host_port_sva (
    input wire aclk,
    input wire aresetn,
    input wire [15:0] switch_addr,
    input wire gpib_jumper,
    input wire strap_sync_sel,
    input wire strap_osc_sel,
    input wire busy_in,
    input wire matrix_start,
    input wire acq_done,
    input wire vme_as_n,
    input wire vme_ds_n,
    input wire vme_write_n,
    input wire [5:0] vme_am,
    input wire [31:1] vme_addr,
    input wire vme_d_oe,
    input wire vme_dtack_oe,
    input wire vme_irq3_oe,
    input wire gpib_srq_oe,
    input wire cmd_wr,
    input wire front_out,
    input wire clk_ext_sel
);
    wire a32 = vme_am[5:4] == 2'h0 && vme_addr[31:16] == switch_addr;
    wire a24 = vme_am[5:4] == 2'h3 && vme_addr[23:16] == switch_addr[7:0];
    wire hit = vme_am[3] && vme_am[0] && (a32 || a24) && !gpib_jumper;
    wire route = strap_sync_sel ? matrix_start : busy_in;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_dtack_timely: assert property (
        $fell(vme_ds_n) && !vme_as_n && hit |-> ##[1:3] vme_dtack_oe)
        else $error("dtack missing");
    a_miss_ignored: assert property (
        $fell(vme_ds_n) && !hit |-> !vme_dtack_oe [*4])
        else $error("foreign cycle answered");
    a_dtack_hold: assert property (
        vme_dtack_oe && !vme_ds_n |=> vme_dtack_oe)
        else $error("dtack dropped early");
    a_dtack_release: assert property (
        vme_dtack_oe && vme_ds_n |=> !vme_dtack_oe)
        else $error("dtack held too long");
    a_read_drive: assert property (
        vme_dtack_oe |-> vme_d_oe == vme_write_n)
        else $error("data drive wrong");
    a_irq_bus: assert property (
        vme_irq3_oe |-> !gpib_jumper || !$past(gpib_jumper))
        else $error("irq on gpib");
    a_srq_bus: assert property (
        gpib_srq_oe |-> gpib_jumper || $past(gpib_jumper))
        else $error("srq on vme");
    a_srq_raise: assert property (
        $rose(acq_done) && gpib_jumper |-> ##[1:3] gpib_srq_oe)
        else $error("srq not raised");
    a_cmd_pulse: assert property (
        cmd_wr |=> !cmd_wr)
        else $error("command strobe too long");
    a_front_route: assert property (
        $past(aresetn) |-> front_out == $past(route))
        else $error("front output wrong");
    a_clk_source: assert property (
        $past(aresetn) |-> clk_ext_sel == !$past(strap_osc_sel))
        else $error("clock sel");
    cover property ($rose(vme_dtack_oe) && vme_write_n);
    cover property ($rose(gpib_srq_oe));
    cover property ($rose(cmd_wr));
endmodule // host_port_sva

// file: dv/vme_master.sv
// vme master model driving single and block cycles
`timescale 1ns/1ps
module vme_master (
    input wire aclk,
    input wire dtack_oe,
    input wire [31:0] d_o,
    output reg as_n,
    output reg ds_n,
    output reg write_n,
    output reg [5:0] am,
    output reg [31:1] addr,
    output reg [31:0] d_i
);
    initial begin
        as_n = 1'b1;
        ds_n = 1'b1;
        write_n = 1'b1;
        am = 6'h00;
        addr = 31'h0;
        d_i = 32'h0;
    end
    // k keeps the address strobe low for a block
    task automatic cyc(input [5:0] m, input [31:0] a, input w,
        input [31:0] wd, input k, output [31:0] rd, output ok);
        integer n;
        n = 0;
        ok = 1'b0;
        @(posedge aclk);
        as_n <= 1'b0;
        ds_n <= 1'b0;
        write_n <= !w;
        am <= m;
        addr <= a[31:1];
        d_i <= w ? wd : ~d_i;
        while (!ok && n < 12) begin
            @(posedge aclk);
            n = n + 1;
            ok = dtack_oe;
        end
        rd = d_o;
        as_n <= !k;
        ds_n <= 1'b1;
        d_i <= ~d_i; // released lines stop showing the last word
        while (dtack_oe && n < 24) begin
            @(posedge aclk);
            n = n + 1;
        end
    endtask
endmodule // vme_master

// file: dv/test_dual_host_bus_access_port.sv
// bench for the dual host bus access port
`timescale 1ns/1ps
`include "host_port_consts.vh"
module test_dual_host_bus_access_port;
    reg aclk = 1'b0, aresetn = 1'b0;
    reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [15:0] switch_addr = 16'h0a12;
    reg gpib_jumper = 1'b0, strap_sync_sel = 1'b0, strap_osc_sel = 1'b0;
    reg busy_in = 1'b0, matrix_start = 1'b0, acq_done = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, vme_d_o, vme_d_i;
    wire vme_as_n, vme_ds_n, vme_write_n, vme_d_oe;
    wire vme_dtack_oe, vme_irq3_oe, gpib_srq_oe, cmd_wr;
    wire gpib_dio_oe, gpib_dav_oe, gpib_nrfd_oe, gpib_ndac_oe;
    wire front_out, clk_ext_sel;
    wire [5:0] vme_am;
    wire [31:1] vme_addr;
    wire [7:0] gpib_dio_o, cmd_sub, reg_addr;
    wire [15:0] cmd_data, ram_addr;
    wire [15:0] ram_rdata = ram_addr ^ 16'h5a00;
    wire [15:0] reg_rdata = {8'h00, reg_addr};
    // gpib controller lines, handshake lines pulled up unless pulled low
    reg [7:0] gpib_dio_i = 8'h00;
    reg gpib_atn_n = 1'b1, gpib_dav_n_i = 1'b1;
    wire gpib_nrfd_n_i = !gpib_nrfd_oe, gpib_ndac_n_i = !gpib_ndac_oe;
    integer failures = 0, checks = 0, i;
    reg [31:0] rd;
    reg ok;
    reg [5:0] am_v;

    host_port dut (.*);
    vme_master m (.aclk(aclk), .dtack_oe(vme_dtack_oe), .d_o(vme_d_o),
        .as_n(vme_as_n), .ds_n(vme_ds_n), .write_n(vme_write_n),
        .am(vme_am), .addr(vme_addr), .d_i(vme_d_i));

    always #2.5 aclk = ~aclk;

    task automatic chk(input [31:0] g, input [31:0] e);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic axi(input w, input [3:0] a, input [31:0] d,
        input [1:0] er);
        integer n;
        n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge aclk);
            n = n + 1;
        end while (n < 20 && !(w ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
        {s_axi_arvalid, s_axi_rready} <= 2'h0;
        chk(w ? {s_axi_bvalid, s_axi_bresp} : {s_axi_rvalid, s_axi_rresp},
            {1'b1, er});
        if (!w)
            chk(s_axi_rdata, d);
    endtask

    task automatic vme(input [5:0] am, input [7:0] sub, input w,
        input [31:0] d, input k, input eok);
        reg [31:0] a;
        a = am[5] ? {8'h00, switch_addr[7:0], sub, 8'h00}
            : {switch_addr, sub, 8'h00};
        m.cyc(am, a, w, d, k, rd, ok);
        chk(ok, eok);
        if (eok && !w)
            chk(rd, d);
    endtask

    // one controller byte, held until the device releases ndac
    task automatic gpib(input atn, input [7:0] b);
        @(posedge aclk);
        {gpib_atn_n, gpib_dio_i, gpib_dav_n_i} <= {!atn, b, 1'b0};
        do
            @(posedge aclk);
        while (gpib_ndac_oe);
        gpib_dav_n_i <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic pulse_done;
        @(posedge aclk);
        acq_done <= 1'b1;
        @(posedge aclk);
        acq_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_axi;
        axi(1'b0, `AXI_CTRL, 32'h0, `AXI_OKAY);
        axi(1'b1, `AXI_CTRL, 32'h2, `AXI_OKAY);
        s_axi_wstrb <= 4'he;
        axi(1'b1, `AXI_CTRL, 32'h0, `AXI_OKAY);
        s_axi_wstrb <= 4'hf;
        axi(1'b0, `AXI_CTRL, 32'h2, `AXI_OKAY);
        axi(1'b1, `AXI_STATUS, 32'h1, `AXI_SLVERR);
        axi(1'b1, 4'hc, 32'h1, `AXI_SLVERR);
        axi(1'b0, 4'hc, 32'h0, `AXI_SLVERR);
        axi(1'b0, `AXI_STATUS, 32'h0, `AXI_OKAY);
        axi(1'b1, `AXI_CTRL, 32'h0, `AXI_OKAY);
        $display("TB: axi end");
    endtask

    task automatic t_vme;
        for (i = 0; i < 8; i = i + 1) begin
            am_v = {{2{i[2]}}, 1'b1, i[1:0], 1'b1};
            vme(am_v, `SUB_CTRL, 1'b1, i, 1'b0, 1'b1);
            vme(am_v, `SUB_CTRL, 1'b0, i, 1'b0, 1'b1);
        end
        vme(6'h29, `SUB_CTRL, 1'b0, 32'h0, 1'b0, 1'b0);
        m.cyc(6'h39, 32'h00131000, 1'b0, 32'h0, 1'b0, rd, ok);
        chk(ok, 1'b0);
        vme(6'h0d, 8'h09, 1'b1, 32'h1234, 1'b0, 1'b1);
        chk({cmd_sub, cmd_data}, 24'h091234);
        vme(6'h0d, `SUB_CTRL, 1'b1, 32'h0, 1'b0, 1'b1);
        vme(6'h0d, 8'h09, 1'b0, 32'h9, 1'b0, 1'b1);
        $display("TB: vme end");
    endtask

    task automatic t_irq;
        pulse_done;
        vme(6'h3d, `SUB_INTR, 1'b0, 32'h1, 1'b0, 1'b1);
        chk(vme_irq3_oe, 1'b1);
        axi(1'b1, `AXI_CTRL, 32'h2, `AXI_OKAY);
        axi(1'b0, `AXI_STATUS, 32'h1, `AXI_OKAY);
        chk(vme_irq3_oe, 1'b0);
        axi(1'b1, `AXI_CTRL, 32'h0, `AXI_OKAY);
        vme(6'h3d, `SUB_INTR, 1'b1, 32'hc3a5, 1'b0, 1'b1);
        vme(6'h3d, `SUB_INTR, 1'b0, 32'h0, 1'b0, 1'b1);
        chk(vme_irq3_oe, 1'b0);
        pulse_done;
        vme(6'h3d, `SUB_LAUNCH, 1'b1, 32'h1, 1'b0, 1'b1);
        vme(6'h3d, `SUB_INTR, 1'b0, 32'h0, 1'b0, 1'b1);
        $display("TB: irq end");
    endtask

    task automatic t_ram;
        pulse_done;
        chk(ram_addr, 32'h0);
        vme(6'h0f, `SUB_PTR_LO, 1'b1, 32'h40, 1'b0, 1'b1);
        vme(6'h0f, `SUB_PTR_HI, 1'b1, 32'h0, 1'b0, 1'b1);
        for (i = 0; i < 4; i = i + 1)
            vme(6'h0f, `SUB_RAM_VME, 1'b0, 32'h5a40 + i, i < 3, 1'b1);
        axi(1'b0, `AXI_PTR, 32'h44, `AXI_OKAY);
        vme(6'h3d, `SUB_INTR, 1'b1, 32'h0, 1'b0, 1'b1);
        $display("TB: ram end");
    endtask

    task automatic t_gpib;
        gpib_jumper <= 1'b1;
        vme(6'h3d, `SUB_INTR, 1'b0, 32'h0, 1'b0, 1'b0);
        pulse_done;
        chk(gpib_srq_oe, 1'b1);
        chk(vme_irq3_oe, 1'b0);
        axi(1'b0, `AXI_STATUS, 32'h3, `AXI_OKAY);
        gpib(1'b1, 8'h32);
        gpib(1'b0, 8'h09);
        gpib(1'b0, 8'h5a);
        chk({cmd_sub, cmd_data}, 24'h09005a);
        gpib(1'b1, 8'h3f);
        gpib(1'b1, 8'h3e);
        gpib(1'b0, `SUB_INTR);
        gpib(1'b0, 8'h77);
        chk(gpib_srq_oe, 1'b0);
        gpib_jumper <= 1'b0;
        vme(6'h3d, `SUB_INTR, 1'b1, 32'h0, 1'b0, 1'b1);
        chk(gpib_srq_oe, 1'b0);
        $display("TB: gpib end");
    endtask

    task automatic t_strap;
        for (i = 0; i < 4; i = i + 1) begin
            {strap_sync_sel, strap_osc_sel} <= {i[0], i[1]};
            {busy_in, matrix_start} <= {i[1], !i[1]};
            repeat (2) @(posedge aclk);
            chk(front_out, i[0] ^ i[1]);
            chk(clk_ext_sel, !i[1]);
        end
        $display("TB: strap end");
    endtask

    task automatic tally_and_finish;
        $display("TB: checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_axi;
        t_vme;
        t_irq;
        t_ram;
        t_gpib;
        t_strap;
        tally_and_finish;
    end

    // more than fifty times the expected run
    initial begin
        #100000;
        failures = failures + 1;
        tally_and_finish;
    end
endmodule // test_dual_host_bus_access_port

bind host_port host_port_sva chk_i (.*);
